// >>> pkg/eew_pkg.sv
// Overview of operation
// RULE1 - Start, opcode, address, data sampled on rising clock
// RULE2 - Host keeps select low for deselect time
// RULE3 - Select low means standby, inputs ignored
// RULE4 - First high data bit after select is start
// RULE5 - Low data clocks before start are dummies
// RULE6 - Every word reads all ones initially
// RULE7 - After last address bit output drives low
// RULE8 - Addressed word shifts out, one bit per clock
// RULE9 - Continued clocks stream next word, address wraps
// RULE10 - Write starts on select fall, inputs then ignored
// RULE11 - Host starts commands only when output high/off
// RULE12 - Write types need program enable state
// RULE13 - Internal write finishes within maximum write time
// RULE14 - Polling shows low while busy, high when done
// RULE15 - Host polls holding select or reselecting later
// RULE16 - Host holds data in low while polling
// RULE17 - High data while ready is start, output off
// RULE18 - Word write overwrites directly with 16 bits
// RULE19 - Too many clocks cancel a write type
// RULE20 - Word erase sets addressed word to ones
// RULE21 - Write all copies one word everywhere
// RULE22 - Erase all sets every word to ones
// RULE23 - Enable and disable commands set program state
// RULE24 - Reset cancels writes, forces program disable
// RULE25 - Too few clocks also cancel a write type
// RULE26 - Opcodes and address width are named constants
// RULE27 - Output is off when idle or deselected; the code drives it high in idle while polling is armed and select is high
package eew_pkg;
	localparam int ADDR_W = 6;
	localparam int WORD_W = 16;
	localparam int MEM_DEPTH = 64;
	localparam int OP_W = 2;
	localparam int CMD_BITS = OP_W + ADDR_W;
	localparam int CNT_W = 5;
	localparam int FIFO_DEPTH = 8;
	// Opcodes, customary three-wire convention
	localparam logic [OP_W-1:0] OP_EXT = 2'h0;
	localparam logic [OP_W-1:0] OP_WRITE = 2'h1;
	localparam logic [OP_W-1:0] OP_READ = 2'h2;
	localparam logic [OP_W-1:0] OP_ERASE = 2'h3;
	// Extended opcodes in the top address bits
	localparam logic [OP_W-1:0] EXT_DISABLE = 2'h0;
	localparam logic [OP_W-1:0] EXT_WRITE_ALL = 2'h1;
	localparam logic [OP_W-1:0] EXT_ERASE_ALL = 2'h2;
	localparam logic [OP_W-1:0] EXT_ENABLE = 2'h3;
	localparam logic [WORD_W-1:0] ERASED_WORD = 16'hffff;
	localparam logic [CNT_W-1:0] CMD_LAST = 5'h07;
	localparam logic [CNT_W-1:0] WORD_LAST = 5'h0f;
	// Timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int DESELECT_TIME_NS = 200;
	localparam int WRITE_TIME_TYP_US = 4000;
	localparam int WRITE_TIME_MAX_US = 8000;
	localparam int WRITE_CYCLES_DEF = WRITE_TIME_TYP_US * 1000 / CLK_PERIOD_NS;
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_CMD = 6'h02,
		ST_READ = 6'h04,
		ST_DATA = 6'h08,
		ST_WAITCS = 6'h10,
		ST_BUSY = 6'h20
	} eew_state_t;
endpackage

// >>> pkg/eew_stream_if.sv
`timescale 1ns/1ps
// Valid/ready word stream between the port logic and its buffer
interface eew_stream_if #(parameter int W = 16) ();
	logic [W-1:0] data;
	logic valid;
	logic ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface

// >>> verilog/eew_fifo.sv
`timescale 1ns/1ps
module eew_fifo #(
	parameter int W = 16,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic flush,
	eew_stream_if.snk in_s,
	eew_stream_if.src out_s
);
	localparam int PW = $clog2(DEPTH);
	logic [W-1:0] store [DEPTH];
	logic [PW:0] wr_ptr;
	logic [PW:0] rd_ptr;
	wire full;
	wire empty;
	wire push;
	wire pop;

	// Flags from pointers with one wrap bit
	assign empty = (wr_ptr == rd_ptr);
	assign full = (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]) && (wr_ptr[PW] != rd_ptr[PW]);
	assign in_s.ready = ~full;
	assign out_s.valid = ~empty;
	assign out_s.data = store[rd_ptr[PW-1:0]];
	assign push = in_s.valid & ~full;
	assign pop = out_s.ready & ~empty;

	// Pointers, flush drops every entry
	always_ff @(posedge clk) begin
		if (sys_rst || flush) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end

	// Storage write
	always_ff @(posedge clk) begin
		if (push)
			store[wr_ptr[PW-1:0]] <= in_s.data;
	end
endmodule // eew_fifo

// >>> verilog/eew_port.sv
`timescale 1ns/1ps
module eew_port import eew_pkg::*; #(
	parameter int WRITE_CYCLES = WRITE_CYCLES_DEF
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic chip_select,
	input wire logic serial_clock_in,
	input wire logic serial_data_in,
	output logic serial_data_out,
	output logic serial_data_out_en,
	output logic program_enabled,
	output logic write_busy
);
	localparam int TW = $clog2(WRITE_CYCLES + 1);

	eew_state_t state;
	eew_state_t next_state;
	logic cs_s1, cs_s2, cs_s3;
	logic sclk_s1, sclk_s2, sclk_s3;
	logic sdin_s1, sdin_s2;
	logic [CNT_W-1:0] cnt;
	logic [CMD_BITS-1:0] cmd_sr;
	logic [WORD_W-1:0] data_sr;
	logic [WORD_W-1:0] rd_sr;
	logic over;
	logic prog_en;
	logic poll_armed;
	logic [ADDR_W-1:0] wr_addr;
	logic [WORD_W-1:0] wr_data;
	logic wr_all;
	logic [TW-1:0] wr_cnt;
	logic [ADDR_W-1:0] pf_addr;
	logic pf_active;
	logic do_en;
	logic do_val;
	logic next_do_en;
	logic next_do_val;
	logic [WORD_W-1:0] mem [MEM_DEPTH];

	eew_stream_if #(.W(WORD_W)) fill_s ();
	eew_stream_if #(.W(WORD_W)) drain_s ();

	// Pin synchronisers, two flops before any use
	always_ff @(posedge clk) begin
		cs_s1 <= chip_select;
		cs_s2 <= cs_s1;
		cs_s3 <= cs_s2;
		sclk_s1 <= serial_clock_in;
		sclk_s2 <= sclk_s1;
		sclk_s3 <= sclk_s2;
		sdin_s1 <= serial_data_in;
		sdin_s2 <= sdin_s1;
	end

	// Edge and frame events
	wire sclk_rise = sclk_s2 & ~sclk_s3 & cs_s2; // RULE1 RULE3
	wire cs_fall = ~cs_s2 & cs_s3;
	wire start_det = (state == ST_IDLE) & sclk_rise & sdin_s2; // RULE4 RULE5 RULE17

	// Command shift and decode
	wire [CMD_BITS-1:0] next_cmd = {cmd_sr[CMD_BITS-2:0], sdin_s2};
	wire cmd_done = (state == ST_CMD) & sclk_rise & (cnt == CMD_LAST);
	wire [OP_W-1:0] new_op = next_cmd[CMD_BITS-1 -: OP_W]; // RULE26
	wire [OP_W-1:0] new_ext = next_cmd[ADDR_W-1 -: OP_W];
	wire new_is_read = (new_op == OP_READ);
	wire new_has_data = (new_op == OP_WRITE) || (new_op == OP_EXT && new_ext == EXT_WRITE_ALL);
	wire [OP_W-1:0] op_q = cmd_sr[CMD_BITS-1 -: OP_W];
	wire [OP_W-1:0] ext_q = cmd_sr[ADDR_W-1 -: OP_W];
	wire [ADDR_W-1:0] addr_q = cmd_sr[ADDR_W-1:0];
	wire is_ext = (op_q == OP_EXT);
	wire is_enable = is_ext && (ext_q == EXT_ENABLE);
	wire is_disable = is_ext && (ext_q == EXT_DISABLE);
	wire is_erase_all = is_ext && (ext_q == EXT_ERASE_ALL);
	wire is_all = is_ext && (ext_q == EXT_WRITE_ALL || ext_q == EXT_ERASE_ALL);
	wire is_wtype = (op_q == OP_WRITE) || (op_q == OP_ERASE) || is_all;
	wire is_erasing = (op_q == OP_ERASE) || is_erase_all;
	wire data_done = (state == ST_DATA) & sclk_rise & (cnt == WORD_LAST);
	wire finish = (state == ST_WAITCS) & ~cs_s2;
	wire wr_go = finish & ~over & prog_en & is_wtype; // RULE10 RULE12 RULE19 RULE25
	wire wr_done = (state == ST_BUSY) && (wr_cnt == TW'(WRITE_CYCLES - 1)); // RULE13
	wire rd_bit0 = (state == ST_READ) & sclk_rise & (cnt == '0);

	// Next state
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (start_det)
					next_state = ST_CMD;
			end
			ST_CMD: begin
				if (~cs_s2)
					next_state = ST_IDLE; // RULE25
				else if (cmd_done && new_is_read)
					next_state = ST_READ;
				else if (cmd_done && new_has_data)
					next_state = ST_DATA;
				else if (cmd_done)
					next_state = ST_WAITCS;
			end
			ST_READ: begin
				if (~cs_s2)
					next_state = ST_IDLE;
			end
			ST_DATA: begin
				if (~cs_s2)
					next_state = ST_IDLE; // RULE25
				else if (data_done)
					next_state = ST_WAITCS; // RULE18
			end
			ST_WAITCS: begin
				if (wr_go)
					next_state = ST_BUSY; // RULE10
				else if (~cs_s2)
					next_state = ST_IDLE;
			end
			ST_BUSY: begin
				if (wr_done)
					next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge clk) begin
		if (sys_rst)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	// Bit counter, shared by command, data and read phases
	always_ff @(posedge clk) begin
		if (sys_rst || start_det || cmd_done || data_done)
			cnt <= '0;
		else if (sclk_rise && state == ST_READ)
			cnt <= (cnt == WORD_LAST) ? '0 : cnt + 1'b1; // RULE8
		else if (sclk_rise && (state == ST_CMD || state == ST_DATA))
			cnt <= cnt + 1'b1;
	end

	// Command and data shift registers
	always_ff @(posedge clk) begin
		if (state == ST_CMD && sclk_rise)
			cmd_sr <= next_cmd; // RULE1
		if (state == ST_DATA && sclk_rise)
			data_sr <= {data_sr[WORD_W-2:0], sdin_s2}; // RULE18 RULE21
	end

	// Extra clocks after the full count cancel the write
	always_ff @(posedge clk) begin
		if (sys_rst || start_det)
			over <= 1'b0;
		else if (state == ST_WAITCS && sclk_rise)
			over <= 1'b1; // RULE19
	end

	// Program enable state, cleared at reset
	always_ff @(posedge clk) begin
		if (sys_rst)
			prog_en <= 1'b0; // RULE24
		else if (finish && ~over && is_enable)
			prog_en <= 1'b1; // RULE23
		else if (finish && ~over && is_disable)
			prog_en <= 1'b0; // RULE23
	end

	// Status polling armed from write start until next start bit
	always_ff @(posedge clk) begin
		if (sys_rst || start_det)
			poll_armed <= 1'b0;
		else if (wr_go)
			poll_armed <= 1'b1;
	end

	// Write job latch and busy timer
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_cnt <= '0;
			wr_all <= 1'b0;
			wr_addr <= '0;
			wr_data <= ERASED_WORD;
		end else if (wr_go) begin
			wr_cnt <= '0;
			wr_all <= is_all; // RULE21 RULE22
			wr_addr <= addr_q;
			wr_data <= is_erasing ? ERASED_WORD : data_sr; // RULE20 RULE22
		end else if (state == ST_BUSY) begin
			wr_cnt <= wr_cnt + 1'b1;
		end
	end

	// Cell array, commit when the write time expires
	generate
		for (genvar i = 0; i < MEM_DEPTH; i++) begin : g_word
			wire hit = wr_done && (wr_all || wr_addr == ADDR_W'(i));
			always_ff @(posedge clk) begin
				if (sys_rst)
					mem[i] <= ERASED_WORD; // RULE6
				else if (hit)
					mem[i] <= wr_data; // RULE18 RULE20 RULE21 RULE22
			end
		end
	endgenerate

	// Read prefetch into the buffer, address wraps at the top
	assign fill_s.valid = pf_active & (state == ST_READ);
	assign fill_s.data = mem[pf_addr];
	assign drain_s.ready = rd_bit0;
	always_ff @(posedge clk) begin
		if (sys_rst || state != ST_READ && !cmd_done)
			pf_active <= 1'b0;
		else if (cmd_done && new_is_read) begin
			pf_active <= 1'b1;
			pf_addr <= next_cmd[ADDR_W-1:0];
		end else if (fill_s.valid && fill_s.ready)
			pf_addr <= pf_addr + 1'b1; // RULE9
	end

	eew_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.sys_rst(sys_rst),
		.flush(state != ST_READ),
		.in_s(fill_s),
		.out_s(drain_s)
	);

	// Read shifter, reloads from the buffer every sixteen bits
	always_ff @(posedge clk) begin
		if (rd_bit0)
			rd_sr <= {drain_s.data[WORD_W-2:0], 1'b0}; // RULE9
		else if (state == ST_READ && sclk_rise)
			rd_sr <= {rd_sr[WORD_W-2:0], 1'b0}; // RULE8
	end

	// Data out drive and level
	always_comb begin
		next_do_en = 1'b0;
		next_do_val = 1'b1;
		if (~cs_s2 || start_det) begin
			next_do_en = 1'b0; // RULE3 RULE17 RULE27
		end else if (cmd_done && new_is_read) begin
			next_do_en = 1'b1;
			next_do_val = 1'b0; // RULE7
		end else if (state == ST_READ) begin
			next_do_en = 1'b1;
			next_do_val = do_val;
			if (rd_bit0)
				next_do_val = drain_s.data[WORD_W-1]; // RULE8
			else if (sclk_rise)
				next_do_val = rd_sr[WORD_W-1]; // RULE8
		end else if (poll_armed && (state == ST_BUSY || state == ST_IDLE)) begin
			next_do_en = 1'b1;
			next_do_val = (state == ST_IDLE); // RULE14
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			do_en <= 1'b0;
			do_val <= 1'b1;
		end else begin
			do_en <= next_do_en;
			do_val <= next_do_val;
		end
	end

	assign serial_data_out = do_val;
	assign serial_data_out_en = do_en;
	assign program_enabled = prog_en;
	assign write_busy = (state == ST_BUSY);

	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	sequence s_read_addr_done;
		cmd_done && new_is_read;
	endsequence

	sequence s_leading_low;
		serial_data_out_en && !serial_data_out;
	endsequence

	property p_standby_quiet;
		!cs_s2 |=> !serial_data_out_en && (state == ST_IDLE || state == ST_BUSY);
	endproperty
	a_standby_quiet: assert property (p_standby_quiet) else $error("output driven while deselected"); // RULE3

	property p_leading_low;
		s_read_addr_done |=> s_leading_low;
	endproperty
	a_leading_low: assert property (p_leading_low) else $error("read low bit missing"); // RULE7

	property p_low_held;
		s_read_addr_done ##1 (!sclk_rise && cs_s2) |=> s_leading_low;
	endproperty
	a_low_held: assert property (p_low_held) else $error("leading low not held"); // RULE7

	property p_first_bit;
		rd_bit0 && cs_s2 |=> serial_data_out == $past(drain_s.data[WORD_W-1]);
	endproperty
	a_first_bit: assert property (p_first_bit) else $error("word msb not shifted out"); // RULE8

	property p_word_ready;
		rd_bit0 |-> drain_s.valid;
	endproperty
	a_word_ready: assert property (p_word_ready) else $error("read word not buffered"); // RULE9

	property p_need_enable;
		$rose(state == ST_BUSY) |-> $past(prog_en) && $past(is_wtype);
	endproperty
	a_need_enable: assert property (p_need_enable) else $error("write without enable"); // RULE12

	property p_overcount_cancel;
		finish && over |=> state == ST_IDLE;
	endproperty
	a_overcount_cancel: assert property (p_overcount_cancel) else $error("overcount write ran"); // RULE19

	property p_undercount_cancel;
		(state == ST_DATA || state == ST_CMD) && !cs_s2 |=> state != ST_BUSY;
	endproperty
	a_undercount_cancel: assert property (p_undercount_cancel) else $error("short write ran"); // RULE25

	property p_busy_deaf;
		state == ST_BUSY && !wr_done |=> state == ST_BUSY;
	endproperty
	a_busy_deaf: assert property (p_busy_deaf) else $error("busy ended early"); // RULE10

	property p_busy_bounded;
		state == ST_BUSY |-> wr_cnt < TW'(WRITE_CYCLES);
	endproperty
	a_busy_bounded: assert property (p_busy_bounded) else $error("write time overrun"); // RULE13

	property p_poll_busy;
		poll_armed && cs_s2 && state == ST_BUSY && !wr_done |=> s_leading_low;
	endproperty
	a_poll_busy: assert property (p_poll_busy) else $error("busy not shown low"); // RULE14

	property p_poll_ready;
		poll_armed && cs_s2 && state == ST_IDLE && !start_det |=>
			serial_data_out_en && serial_data_out;
	endproperty
	a_poll_ready: assert property (p_poll_ready) else $error("ready not shown high"); // RULE14

	property p_start_release;
		start_det |=> !serial_data_out_en && state == ST_CMD ##1 !serial_data_out_en;
	endproperty
	a_start_release: assert property (p_start_release) else $error("output kept after start"); // RULE17

	property p_enable_cmd;
		finish && !over && is_enable |=> prog_en;
	endproperty
	a_enable_cmd: assert property (p_enable_cmd) else $error("enable not taken"); // RULE23

	property p_erase_value;
		$rose(state == ST_BUSY) && $past(is_erasing) |-> wr_data == ERASED_WORD;
	endproperty
	a_erase_value: assert property (p_erase_value) else $error("erase data not ones"); // RULE20
endmodule // eew_port

// >>> sim/eew_host.sv
`timescale 1ns/1ps
// Host controller model driving the three-wire link
module eew_host (
	input wire logic clk,
	input wire logic serial_data_out,
	input wire logic serial_data_out_en,
	output logic chip_select,
	output logic serial_clock_in,
	output logic serial_data_in
);
	logic [31:0] got;
	// Quiet lines at time zero
	initial begin
		chip_select = 1'b0;
		serial_clock_in = 1'b0;
		serial_data_in = 1'b0;
		got = 32'h0;
	end
	// Wait a number of system clocks
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Select change; a low select is held past the deselect time
	task automatic sel(input logic v);
		@(posedge clk);
		chip_select <= v;
		serial_clock_in <= 1'b0;
		serial_data_in <= 1'b0;
		wait_clk(12);
	endtask
	// Bits go out MSB first from bit 31; data out is sampled before each rise
	task automatic shift(input logic [31:0] v, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			serial_clock_in <= 1'b0;
			serial_data_in <= v[31-i];
			wait_clk(3);
			@(posedge clk);
			// Released line has no pull, so it reads as the inverse
			got <= {got[30:0], serial_data_out_en ? serial_data_out : ~serial_data_out};
			serial_clock_in <= 1'b1;
			wait_clk(3);
		end
	endtask
endmodule // eew_host

// >>> sim/tb.sv
`timescale 1ns/1ps
module tb;
	import eew_pkg::*;
	localparam int WC = 400;
	logic clk;
	logic sys_rst;
	logic chip_select;
	logic serial_clock_in;
	logic serial_data_in;
	logic serial_data_out;
	logic serial_data_out_en;
	logic program_enabled;
	logic write_busy;
	int n_mismatch;
	int samples_checked;
	logic [15:0] w;

	eew_port #(.WRITE_CYCLES(WC)) DUT (
		.clk(clk),
		.sys_rst(sys_rst),
		.chip_select(chip_select),
		.serial_clock_in(serial_clock_in),
		.serial_data_in(serial_data_in),
		.serial_data_out(serial_data_out),
		.serial_data_out_en(serial_data_out_en),
		.program_enabled(program_enabled),
		.write_busy(write_busy)
	);

	eew_host host (
		.clk(clk),
		.serial_data_out(serial_data_out),
		.serial_data_out_en(serial_data_out_en),
		.chip_select(chip_select),
		.serial_clock_in(serial_clock_in),
		.serial_data_in(serial_data_in)
	);

	// System clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic wrap_up;
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Comparisons
	task automatic chk_bit(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL %0t bit got %b exp %b", $time, got, exp);
		end
	endtask
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL %0t word got %h exp %h", $time, got, exp);
		end
	endtask

	// One framed command with nd data clocks
	task automatic do_cmd(input logic [1:0] op, input logic [5:0] a,
		input logic [15:0] d, input int nd);
		host.sel(1'b1);
		host.shift({1'b1, op, a, 23'h0}, 9);
		if (nd > 0) begin
			host.shift({d, 16'h0}, nd);
		end
		host.sel(1'b0);
	endtask
	// Read one word after three dummy clocks, then check the line is released
	task automatic read_word(input logic [5:0] a, output logic [15:0] v);
		host.sel(1'b1);
		host.shift(32'h0, 3);
		host.shift({1'b1, OP_READ, a, 23'h0}, 9);
		host.shift(32'h0, 17);
		chk_bit(host.got[16], 1'b0);
		chk_bit(serial_data_out_en, 1'b1);
		v = host.got[15:0];
		host.sel(1'b0);
		chk_bit(serial_data_out_en, 1'b0);
	endtask
	// Bounded wait for the internal write
	task automatic wait_done;
		int n;
		n = 0;
		chk_bit(write_busy, 1'b1);
		while (write_busy === 1'b1 && n < WC + 20) begin
			@(posedge clk);
			n++;
		end
		chk_bit(write_busy, 1'b0);
	endtask

	task automatic t_idle;
		chk_bit(serial_data_out_en, 1'b0);
		chk_bit(program_enabled, 1'b0);
		chk_bit(write_busy, 1'b0);
		host.shift({1'b1, OP_READ, 6'h05, 23'h0}, 9);
		host.shift(32'h0, 4);
		chk_bit(serial_data_out_en, 1'b0);
		read_word(6'h05, w);
		chk_word(w, ERASED_WORD);
	endtask

	task automatic t_protect;
		do_cmd(OP_WRITE, 6'h01, 16'h0f0f, 16);
		chk_bit(write_busy, 1'b0);
		do_cmd(OP_EXT, {EXT_ENABLE, 4'h0}, 16'h0, 0);
		chk_bit(program_enabled, 1'b1);
		read_word(6'h01, w);
		chk_word(w, ERASED_WORD);
	endtask

	task automatic t_write_poll;
		do_cmd(OP_WRITE, 6'h00, 16'h1234, 16);
		chk_bit(write_busy, 1'b1);
		host.sel(1'b1);
		chk_bit(serial_data_out_en, 1'b1);
		chk_bit(serial_data_out, 1'b0);
		host.shift({1'b1, OP_EXT, EXT_DISABLE, 27'h0}, 9);
		host.sel(1'b0);
		chk_bit(program_enabled, 1'b1);
		host.sel(1'b1);
		wait_done;
		host.wait_clk(8);
		chk_bit(serial_data_out_en, 1'b1);
		chk_bit(serial_data_out, 1'b1);
		host.shift({1'b1, 31'h0}, 1);
		host.wait_clk(6);
		chk_bit(serial_data_out_en, 1'b0);
		host.shift({OP_READ, 6'h3f, 24'h0}, 8);
		host.shift(32'h0, 17);
		chk_word(host.got[15:0], ERASED_WORD);
		host.shift(32'h0, 16);
		chk_word(host.got[15:0], 16'h1234);
		host.sel(1'b0);
	endtask

	task automatic t_count;
		do_cmd(OP_WRITE, 6'h02, 16'h5a5a, 17);
		chk_bit(write_busy, 1'b0);
		do_cmd(OP_WRITE, 6'h02, 16'h5a5a, 15);
		chk_bit(write_busy, 1'b0);
		read_word(6'h02, w);
		chk_word(w, ERASED_WORD);
	endtask

	task automatic t_erase_all;
		do_cmd(OP_ERASE, 6'h00, 16'h0, 0);
		wait_done;
		read_word(6'h00, w);
		chk_word(w, ERASED_WORD);
		do_cmd(OP_EXT, {EXT_WRITE_ALL, 4'h9}, 16'h00a5, 16);
		wait_done;
		read_word(6'h07, w);
		chk_word(w, 16'h00a5);
		do_cmd(OP_EXT, {EXT_ERASE_ALL, 4'h3}, 16'h0, 0);
		wait_done;
		read_word(6'h07, w);
		chk_word(w, ERASED_WORD);
		do_cmd(OP_EXT, {EXT_DISABLE, 4'h0}, 16'h0, 0);
		chk_bit(program_enabled, 1'b0);
	endtask

	// Reset in mid-write, then writes stay locked out
	task automatic t_reset;
		do_cmd(OP_EXT, {EXT_ENABLE, 4'h0}, 16'h0, 0);
		chk_bit(program_enabled, 1'b1);
		do_cmd(OP_WRITE, 6'h04, 16'h0bad, 16);
		chk_bit(write_busy, 1'b1);
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		host.wait_clk(2);
		chk_bit(write_busy, 1'b0);
		chk_bit(program_enabled, 1'b0);
		chk_bit(serial_data_out_en, 1'b0);
		do_cmd(OP_WRITE, 6'h04, 16'h0bad, 16);
		chk_bit(write_busy, 1'b0);
		read_word(6'h04, w);
		chk_word(w, ERASED_WORD);
	endtask

	// Reset, then the scenarios in order
	initial begin
		n_mismatch = 0;
		samples_checked = 0;
		sys_rst = 1'b1;
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		host.wait_clk(4);
		t_idle;
		t_protect;
		t_write_poll;
		t_count;
		t_erase_all;
		t_reset;
		wrap_up;
	end

	// Hang guard, well past the expected run length
	initial begin
		repeat (40000) @(posedge clk);
		n_mismatch++;
		wrap_up;
	end
endmodule // tb
